// ---- common/gbg_pkg.sv ----
// constants, types and helpers shared by the geometry register bank
package gbg_pkg;

    // word indices on the avalon bus; byte address is four times the index
    localparam logic [2:0] IDX_WORK_AREA_HEIGHT = 3'h0;
    localparam logic [2:0] IDX_FRAME_BASE_LOW   = 3'h1;
    localparam logic [2:0] IDX_FRAME_BASE_HIGH  = 3'h2;
    localparam logic [2:0] IDX_FRAME_WIDTH      = 3'h3;
    localparam logic [2:0] IDX_FRAME_HEIGHT     = 3'h4;

    // implemented bits of each 16-bit register
    localparam logic [15:0] MASK_WORK_AREA_HEIGHT = 16'h07ff;
    localparam logic [15:0] MASK_FRAME_BASE_LOW   = 16'hffff;
    localparam logic [15:0] MASK_FRAME_BASE_HIGH  = 16'h00ff;
    localparam logic [15:0] MASK_FRAME_WIDTH      = 16'h07ff;
    localparam logic [15:0] MASK_FRAME_HEIGHT     = 16'h07ff;

    // values after reset
    localparam logic [15:0] RST_WORK_AREA_HEIGHT = 16'h0000;
    localparam logic [15:0] RST_FRAME_BASE_LOW   = 16'h0000;
    localparam logic [15:0] RST_FRAME_BASE_HIGH  = 16'h0000;
    localparam logic [15:0] RST_FRAME_WIDTH      = 16'h0000;
    localparam logic [15:0] RST_FRAME_HEIGHT     = 16'h0000;
    localparam logic [31:0] RST_READDATA         = 32'h0000_0000;

    // field widths and positions
    localparam int SIZE_W      = 11;
    localparam int ADDR_W      = 24;
    localparam int HIGH_LSB    = 16;
    localparam int HIGH_W      = 8;

    // avalon response codes
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_DECODEERROR = 2'h3;

    typedef enum logic {
        GBG_IDLE,
        GBG_ACK
    } gbg_state_t;

    // byte-lane merge, then clip to the implemented bits
    function automatic logic [15:0] gbg_merge(
        input logic [15:0] old_val,
        input logic [15:0] wdata,
        input logic [1:0]  be,
        input logic [15:0] mask
    );
        logic [15:0] lanes;
        lanes = {{8{be[1]}}, {8{be[0]}}};
        return ((old_val & ~lanes) | (wdata & lanes)) & mask;
    endfunction

endpackage

// ---- common/gbg_bank_if.sv ----
// carrier between the bus slave and the register bank
`timescale 1ns/1ps
interface gbg_bank_if;
    logic        wr;
    logic [2:0]  idx;
    logic [15:0] wdata;
    logic [1:0]  be;
    logic [15:0] rdata;
    logic        hit;
    logic [15:0] work_area_height;
    logic [15:0] frame_base_low;
    logic [15:0] frame_base_high;
    logic [15:0] frame_width;
    logic [15:0] frame_height;

    modport bus (
        output wr,
        output idx,
        output wdata,
        output be,
        input  rdata,
        input  hit,
        input  work_area_height,
        input  frame_base_low,
        input  frame_base_high,
        input  frame_width,
        input  frame_height
    );

    modport bank (
        input  wr,
        input  idx,
        input  wdata,
        input  be,
        output rdata,
        output hit,
        output work_area_height,
        output frame_base_low,
        output frame_base_high,
        output frame_width,
        output frame_height
    );
endinterface

// ---- hw/gbg_bank.sv ----
// storage of the five geometry registers with masked byte-lane writes
`timescale 1ns/1ps
module gbg_bank (
    input  wire logic  clock,
    input  wire logic  sys_rst,
    gbg_bank_if.bank   bif
);

    typedef struct packed {
        logic [15:0] work_area_height;
        logic [15:0] frame_base_low;
        logic [15:0] frame_base_high;
        logic [15:0] frame_width;
        logic [15:0] frame_height;
    } gbg_bank_state_t;

    gbg_bank_state_t q;
    gbg_bank_state_t next_q;

    always_comb begin
        next_q = q;
        if (bif.wr) begin
            case (bif.idx)
                gbg_pkg::IDX_WORK_AREA_HEIGHT: begin
                    next_q.work_area_height = gbg_pkg::gbg_merge(
                        q.work_area_height, bif.wdata, bif.be,
                        gbg_pkg::MASK_WORK_AREA_HEIGHT);
                end
                gbg_pkg::IDX_FRAME_BASE_LOW: begin
                    // bit 0 kept as written; software keeps it even
                    next_q.frame_base_low = gbg_pkg::gbg_merge(
                        q.frame_base_low, bif.wdata, bif.be,
                        gbg_pkg::MASK_FRAME_BASE_LOW);
                end
                gbg_pkg::IDX_FRAME_BASE_HIGH: begin
                    next_q.frame_base_high = gbg_pkg::gbg_merge(
                        q.frame_base_high, bif.wdata, bif.be,
                        gbg_pkg::MASK_FRAME_BASE_HIGH);
                end
                gbg_pkg::IDX_FRAME_WIDTH: begin
                    next_q.frame_width = gbg_pkg::gbg_merge(
                        q.frame_width, bif.wdata, bif.be,
                        gbg_pkg::MASK_FRAME_WIDTH);
                end
                gbg_pkg::IDX_FRAME_HEIGHT: begin
                    next_q.frame_height = gbg_pkg::gbg_merge(
                        q.frame_height, bif.wdata, bif.be,
                        gbg_pkg::MASK_FRAME_HEIGHT);
                end
                default: begin
                    next_q = q;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q.work_area_height <= gbg_pkg::RST_WORK_AREA_HEIGHT;
            q.frame_base_low   <= gbg_pkg::RST_FRAME_BASE_LOW;
            q.frame_base_high  <= gbg_pkg::RST_FRAME_BASE_HIGH;
            q.frame_width      <= gbg_pkg::RST_FRAME_WIDTH;
            q.frame_height     <= gbg_pkg::RST_FRAME_HEIGHT;
        end else begin
            q <= next_q;
        end
    end

    // read mux straight from the flops; stored values are already masked
    always_comb begin
        bif.hit   = 1'b1;
        bif.rdata = 16'h0000;
        case (bif.idx)
            gbg_pkg::IDX_WORK_AREA_HEIGHT: bif.rdata = q.work_area_height;
            gbg_pkg::IDX_FRAME_BASE_LOW:   bif.rdata = q.frame_base_low;
            gbg_pkg::IDX_FRAME_BASE_HIGH:  bif.rdata = q.frame_base_high;
            gbg_pkg::IDX_FRAME_WIDTH:      bif.rdata = q.frame_width;
            gbg_pkg::IDX_FRAME_HEIGHT:     bif.rdata = q.frame_height;
            default: begin
                bif.hit   = 1'b0;
                bif.rdata = 16'h0000;
            end
        endcase
    end

    assign bif.work_area_height = q.work_area_height;
    assign bif.frame_base_low   = q.frame_base_low;
    assign bif.frame_base_high  = q.frame_base_high;
    assign bif.frame_width      = q.frame_width;
    assign bif.frame_height     = q.frame_height;

endmodule // gbg_bank

// ---- hw/gbg_regs.sv ----
// avalon-mm slave front end for the buffer geometry register bank
`timescale 1ns/1ps
module gbg_regs (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  avs_response,
    output logic      [10:0] work_area_height_field,
    output logic      [23:0] frame_base_address,
    output logic      [10:0] frame_width_field,
    output logic      [10:0] frame_height_field
);

    typedef struct packed {
        gbg_pkg::gbg_state_t state;
        logic                waitrequest;
        logic [31:0]         readdata;
        logic [1:0]          response;
    } gbg_slave_state_t;

    gbg_slave_state_t q;
    gbg_slave_state_t next_q;

    gbg_bank_if bif ();

    gbg_bank u_bank (
        .clock   (clock),
        .sys_rst (sys_rst),
        .bif     (bif)
    );

    // master holds the request through ack, so live bus signals are used
    assign bif.idx   = avs_address;
    assign bif.wdata = avs_writedata[15:0];
    assign bif.be    = avs_byteenable[1:0];
    // write commits on the edge where waitrequest is seen low
    assign bif.wr    = (q.state == gbg_pkg::GBG_ACK) && avs_write;

    // one wait cycle per access: simple, fixed latency, no pipelining
    always_comb begin
        next_q = q;
        case (q.state)
            gbg_pkg::GBG_IDLE: begin
                next_q.waitrequest = 1'b1;
                if (avs_read || avs_write) begin
                    next_q.state       = gbg_pkg::GBG_ACK;
                    next_q.waitrequest = 1'b0;
                    next_q.response    = bif.hit ? gbg_pkg::RESP_OKAY
                                                 : gbg_pkg::RESP_DECODEERROR;
                    // upper half and unmapped words read zero
                    next_q.readdata    = (avs_read && bif.hit)
                                       ? {16'h0000, bif.rdata}
                                       : gbg_pkg::RST_READDATA;
                end
            end
            gbg_pkg::GBG_ACK: begin
                next_q.state       = gbg_pkg::GBG_IDLE;
                next_q.waitrequest = 1'b1;
            end
            default: begin
                next_q.state       = gbg_pkg::GBG_IDLE;
                next_q.waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q.state       <= gbg_pkg::GBG_IDLE;
            q.waitrequest <= 1'b1;
            q.readdata    <= gbg_pkg::RST_READDATA;
            q.response    <= gbg_pkg::RESP_OKAY;
        end else begin
            q <= next_q;
        end
    end

    assign avs_readdata    = q.readdata;
    assign avs_waitrequest = q.waitrequest;
    assign avs_response    = q.response;

    // field outputs come straight from the bank flops
    assign work_area_height_field = bif.work_area_height[gbg_pkg::SIZE_W-1:0];
    assign frame_base_address     = {
        bif.frame_base_high[gbg_pkg::HIGH_W-1:0],
        bif.frame_base_low
    };
    assign frame_width_field      = bif.frame_width[gbg_pkg::SIZE_W-1:0];
    assign frame_height_field     = bif.frame_height[gbg_pkg::SIZE_W-1:0];

endmodule // gbg_regs

// ---- dv/gbg_regs_properties.sv ----
// concurrent checks on the geometry register bank ports
`timescale 1ns/1ps
module gbg_props (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire logic [10:0] work_area_height_field,
    input wire logic [23:0] frame_base_address,
    input wire logic [10:0] frame_width_field,
    input wire logic [10:0] frame_height_field
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // full-lane write acknowledged at index i
    sequence s_wr(logic [2:0] i);
        avs_write && !avs_waitrequest && avs_address == i
            && avs_byteenable[1:0] == 2'h3;
    endsequence
    sequence s_rd(logic [2:0] i);
        avs_read && !avs_waitrequest && avs_address == i;
    endsequence
    property p_wah;
        s_wr(3'h0) |=> work_area_height_field == $past(avs_writedata[10:0]);
    endproperty
    property p_lo;
        s_wr(3'h1) |=> frame_base_address[15:0] == $past(avs_writedata[15:0]);
    endproperty
    property p_hi;
        s_wr(3'h2) |=> frame_base_address[23:16] == $past(avs_writedata[7:0]);
    endproperty
    property p_wid;
        s_wr(3'h3) |=> frame_width_field == $past(avs_writedata[10:0]);
    endproperty
    property p_hgt;
        s_wr(3'h4) |=> frame_height_field == $past(avs_writedata[10:0]);
    endproperty
    property p_hold;
        !(avs_write && !avs_waitrequest) |=> $stable({work_area_height_field,
            frame_base_address, frame_width_field, frame_height_field});
    endproperty
    property p_rd0;
        s_rd(3'h0) |-> avs_readdata == {21'h0, work_area_height_field};
    endproperty
    property p_rd2;
        s_rd(3'h2) |-> avs_readdata == {24'h0, frame_base_address[23:16]};
    endproperty
    a_wah: assert property (p_wah) else $error("height field wrong");
    a_lo: assert property (p_lo) else $error("base low wrong");
    a_hi: assert property (p_hi) else $error("base high wrong");
    a_wid: assert property (p_wid) else $error("width wrong");
    a_hgt: assert property (p_hgt) else $error("frame height wrong");
    a_hold: assert property (p_hold) else $error("field moved");
    a_rd0: assert property (p_rd0) else $error("height readback");
    a_rd2: assert property (p_rd2) else $error("high readback");
endmodule // gbg_props

// ---- dv/tb_gbg_regs.sv ----
// self-checking bench for the geometry register bank
`timescale 1ns/1ps
module tb_gbg_regs;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [2:0]  avs_address = 3'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    logic [10:0] wah;
    logic [23:0] fba;
    logic [10:0] fw;
    logic [10:0] fh;
    logic [31:0] lfsr = 32'h0001_4ec7;
    logic [15:0] mdl [8];
    logic [15:0] msk [8] = '{gbg_pkg::MASK_WORK_AREA_HEIGHT,
        gbg_pkg::MASK_FRAME_BASE_LOW, gbg_pkg::MASK_FRAME_BASE_HIGH,
        gbg_pkg::MASK_FRAME_WIDTH, gbg_pkg::MASK_FRAME_HEIGHT,
        16'h0, 16'h0, 16'h0};
    logic [33:0] exp_q [$];
    logic [2:0]  a;
    logic [15:0] d;
    int          num_errors = 0;
    int          check_count = 0;
    int          i;

    always #5 clock = ~clock;

    gbg_regs DUT (.clock(clock), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .work_area_height_field(wah), .frame_base_address(fba),
        .frame_width_field(fw), .frame_height_field(fh));

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0];
    endfunction

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] expv);
        check_count++;
        if (seen !== expv) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, expv, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // request stays up on return so back-to-back calls need no idle edge
    task automatic acc(input logic wr, input logic [2:0] ad,
                       input logic [15:0] dt, input logic [1:0] be);
        logic [15:0] ln;
        ln = {{8{be[1]}}, {8{be[0]}}};
        avs_address <= ad;
        avs_writedata <= {rnd(), dt};
        avs_byteenable <= {be, be};
        avs_write <= wr;
        avs_read <= !wr;
        if (!wr)
            exp_q.push_back({ad > 3'h4 ? 2'h3 : 2'h0, 16'h0, mdl[ad]});
        else
            mdl[ad] = ((mdl[ad] & ~ln) | (dt & ln)) & msk[ad];
        // no cycle count assumed here; a hang is ended by the watchdog
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
    endtask

    task automatic idle_chk();
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
        check("fields", {wah, fba, fw, fh},
            {mdl[0][10:0], mdl[2][7:0], mdl[1], mdl[3][10:0], mdl[4][10:0]});
    endtask

    task automatic read_all();
        for (i = 0; i < 8; i++)
            acc(1'b0, 3'(i), 16'h0, 2'h3);
        idle_chk();
    endtask

    always @(posedge clock)
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && !sys_rst)
            check("read", {avs_response, avs_readdata},
                exp_q.pop_front());

    initial begin
        for (i = 0; i < 8; i++)
            mdl[i] = 16'h0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        read_all();
        $display("test reset values done");
        for (i = 0; i < 8; i++)
            acc(1'b1, 3'(i), i == 1 ? 16'hfffe : 16'hffff, 2'h3);
        read_all();
        $display("test unused bits done");
        for (int k = 0; k < 60; k++) begin
            a = 3'(rnd());
            d = rnd();
            if (a == 3'h1)
                d[0] = 1'b0;
            acc(1'b1, a, d, 2'(rnd()));
            acc(1'b0, a, 16'h0, 2'h3);
            idle_chk();
        end
        $display("test random lanes done");
        sys_rst <= 1'b1;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i++)
            mdl[i] = 16'h0;
        read_all();
        $display("test second reset done");
        give_verdict();
    end

    // whole run is well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        give_verdict();
    end
endmodule // tb_gbg_regs

bind gbg_regs gbg_props u_props (.clock(clock), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .work_area_height_field(work_area_height_field),
    .frame_base_address(frame_base_address),
    .frame_width_field(frame_width_field),
    .frame_height_field(frame_height_field));
